// ---- src/sbt_pkg.sv ----
// Constants shared by the sleep and balance timer block.
// Assumes a 250 MHz clock and a 32-bit APB register bus.
package sbt_pkg;

  // APB word offsets
  localparam logic [7:0] SLEEP_DELAY_OFS = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] BAL_CTRL_OFS = 8'h08;
  localparam logic [7:0] ON_TIME0_OFS = 8'h0c;
  localparam logic [7:0] ON_TIME5_OFS = 8'h20;
  localparam logic [7:0] STATUS_OFS = 8'h24;

  // Field positions
  localparam int STEP_LSB = 3;
  localparam int STEP_MSB = 7;
  localparam int BAL_LSB = 2;
  localparam int BAL_MSB = 7;
  localparam int SOFT_SLEEP_POS = 8;
  localparam int STAT_STATE_LSB = 16;

  // Reset values
  localparam logic [4:0] STEP_RESET = 5'h00;
  localparam logic [5:0] BAL_RESET = 6'h00;

  // Timing
  localparam longint unsigned CLK_PERIOD_NS = 4;
  localparam longint unsigned TICK_TIME_MS = 4500;
  localparam longint unsigned TICK_CYCLES =
    TICK_TIME_MS * 64'd1000000 / CLK_PERIOD_NS;
  localparam longint unsigned FILTER_TIME_US = 130;
  localparam longint unsigned FILTER_CYCLES =
    (FILTER_TIME_US * 64'd1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICKS_PER_STEP_LOG2 = 4;

  typedef enum logic [1:0]
  {
    SBT_IDLE = 2'b00,
    SBT_RUN = 2'b01,
    SBT_DOWN = 2'b10
  } sbt_sleep_e;

endpackage

// ---- src/sbt_top.sv ----
// Sleep delay timer and six balance output timers behind an APB slave.
// Assumes a synchronous sleep request pin and an APB3 master.
//
// What this block does
// - Sleep delay programmable 0 to 31 steps of 72 s.
// - Sleep timer starts on pin falling edge or soft sleep bit set.
// - At expiry, pin low powers down, pin high keeps running.
// - Sleep delay register resets to zero.
// - Delay write while running clears counter and recounts to new value.
// - Zero written while running checks the pin at once.
// - Pin rising edge does not cancel a running sleep timer.
// - Six balance outputs follow control bits, reset all off.
// - Zero delay: falling edge drops outputs and powers down.
// - Balance timers never affect the sleep timer; power-down clears the balance outputs and counter.
// - Six on-time registers, 0 to 31 steps of 72 s.
// - Zero on-time means untimed; timing starts on control write.
// - Expiry drops output and its control bit; on-times kept.
// - Shared counter starts on nonzero control write with armed on-time.
// - Every 4.5 s each on-time is compared with the counter.
// - Control writes win over timer expiry.
// - On-time write to an active output restarts counter; zero drops it.
// - On-time write to an inactive output leaves the counter.
// - Output added to a running count is timed against it.
// - Sleep pin filtered for about 130 us in both directions.
`timescale 1ns/1ns
`default_nettype none

module sbt_top
#(
  parameter int unsigned P_TICK_CYCLES = 32'(sbt_pkg::TICK_CYCLES),
  parameter int unsigned P_FILTER_CYCLES = 32'(sbt_pkg::FILTER_CYCLES)
)
(
  // Clock, reset, enable
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic I_CLOCK_EN,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Pins
  input wire logic I_SLEEP_REQUEST_N,
  output logic [5:0] O_BALANCE_DRIVE,
  output logic O_POWER_DOWN
);
  import sbt_pkg::*;

  function automatic logic [8:0] step_ticks(input logic [4:0] s);
    step_ticks = {s, 4'h0};
  endfunction

  logic [30:0] tick_cnt;
  logic tick;
  logic [30:0] filt_cnt;
  logic pin_filt;
  logic pin_prev;
  logic [4:0] sleep_delay;
  logic soft_sleep_bit;
  logic [8:0] sleep_cnt;
  sbt_sleep_e state;
  logic [5:0] bal;
  logic [4:0] on_time [6];
  logic [8:0] bal_cnt;
  logic bal_run;
  logic access;
  logic wr;
  logic rd_ok;
  logic [31:0] rd_data;
  logic wr_delay;
  logic wr_ctrl;
  logic wr_bal;
  logic [5:0] wr_on;
  logic trigger;
  logic [8:0] next_sleep_cnt;
  logic [8:0] next_bal_cnt;
  logic [5:0] expired;
  logic any_armed;

  assign access = I_PSEL && I_PENABLE && O_PREADY;
  assign wr = access && I_PWRITE;
  assign next_sleep_cnt = sleep_cnt + 9'h001;
  assign next_bal_cnt = bal_cnt + 9'h001;

  always_comb
  begin
    wr_delay = 1'b0;
    wr_ctrl = 1'b0;
    wr_bal = 1'b0;
    wr_on = 6'h00;
    if (wr && I_PADDR == SLEEP_DELAY_OFS)
      wr_delay = 1'b1;
    else if (wr && I_PADDR == CONTROL_OFS)
      wr_ctrl = 1'b1;
    else if (wr && I_PADDR == BAL_CTRL_OFS)
      wr_bal = 1'b1;
    else if (wr && I_PADDR >= ON_TIME0_OFS && I_PADDR <= ON_TIME5_OFS
             && I_PADDR[1:0] == 2'b00)
      wr_on = 6'h01 << 3'(I_PADDR[7:2] - ON_TIME0_OFS[7:2]);
  end

  always_comb
  begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    if (I_PADDR == SLEEP_DELAY_OFS)
      rd_data[STEP_MSB:STEP_LSB] = sleep_delay;
    else if (I_PADDR == CONTROL_OFS)
      rd_data[SOFT_SLEEP_POS] = soft_sleep_bit;
    else if (I_PADDR == BAL_CTRL_OFS)
      rd_data[BAL_MSB:BAL_LSB] = bal;
    else if (I_PADDR >= ON_TIME0_OFS && I_PADDR <= ON_TIME5_OFS
             && I_PADDR[1:0] == 2'b00)
      rd_data[STEP_MSB:STEP_LSB] =
        on_time[3'(I_PADDR[7:2] - ON_TIME0_OFS[7:2])];
    else if (I_PADDR == STATUS_OFS)
      rd_data = {14'h0000, 2'(state), 7'h00, bal_cnt};
    else
      rd_ok = 1'b0;
  end

  // APB answer: one wait state, data registered with pready
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
    else if (I_CLOCK_EN)
    begin
      O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
      if (I_PSEL && I_PENABLE && !O_PREADY)
      begin
        O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rd_data;
        O_PSLVERR <= !rd_ok;
      end
      else
        O_PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      tick_cnt <= 31'h0000_0000;
      tick <= 1'b0;
    end
    else if (I_CLOCK_EN)
    begin
      tick <= tick_cnt == 31'(P_TICK_CYCLES - 1);
      if (tick_cnt == 31'(P_TICK_CYCLES - 1))
        tick_cnt <= 31'h0000_0000;
      else
        tick_cnt <= tick_cnt + 31'h0000_0001;
    end
  end

  // Pin accepted only after a stable run of the filter time
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      filt_cnt <= 31'h0000_0000;
      pin_filt <= 1'b1;
      pin_prev <= 1'b1;
    end
    else if (I_CLOCK_EN)
    begin
      pin_prev <= pin_filt;
      if (I_SLEEP_REQUEST_N == pin_filt)
        filt_cnt <= 31'h0000_0000;
      else if (filt_cnt == 31'(P_FILTER_CYCLES - 1))
      begin
        filt_cnt <= 31'h0000_0000;
        pin_filt <= I_SLEEP_REQUEST_N;
      end
      else
        filt_cnt <= filt_cnt + 31'h0000_0001;
    end
  end

  // Falling edge of filtered pin or setting the soft bit
  assign trigger = (pin_prev && !pin_filt)
    || (wr_ctrl && I_PWDATA[SOFT_SLEEP_POS] && !soft_sleep_bit);

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      sleep_delay <= STEP_RESET;
    else if (I_CLOCK_EN && wr_delay)
      sleep_delay <= I_PWDATA[STEP_MSB:STEP_LSB];
  end

  // Soft bit: set by software wins over the clear at the end of a sleep
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      soft_sleep_bit <= 1'b0;
    else if (I_CLOCK_EN)
    begin
      if (wr_ctrl && I_PWDATA[SOFT_SLEEP_POS])
        soft_sleep_bit <= 1'b1;
      else if (wr_ctrl || (state == SBT_DOWN && pin_filt && !pin_prev))
        soft_sleep_bit <= 1'b0;
      else if (state == SBT_RUN && pin_filt && tick
               && next_sleep_cnt >= step_ticks(sleep_delay))
        soft_sleep_bit <= 1'b0;
    end
  end

  // Sleep delay timer; it only reads its own counter
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      state <= SBT_IDLE;
      sleep_cnt <= 9'h000;
    end
    else if (I_CLOCK_EN)
    begin
      case (state)
        SBT_IDLE:
        begin
          sleep_cnt <= 9'h000;
          // zero delay checks the pin at once
          if (trigger && sleep_delay == STEP_RESET)
            state <= pin_filt ? SBT_IDLE : SBT_DOWN;
          else if (trigger)
            state <= SBT_RUN;
        end
        SBT_RUN:
        begin
          // rewrite restarts count; zero checks pin now
          if (wr_delay)
          begin
            sleep_cnt <= 9'h000;
            if (I_PWDATA[STEP_MSB:STEP_LSB] == STEP_RESET)
              state <= pin_filt ? SBT_IDLE : SBT_DOWN;
          end
          // expiry samples the pin; edges alone never stop it
          else if (tick)
          begin
            sleep_cnt <= next_sleep_cnt;
            if (next_sleep_cnt >= step_ticks(sleep_delay))
              state <= pin_filt ? SBT_IDLE : SBT_DOWN;
          end
        end
        SBT_DOWN:
        begin
          sleep_cnt <= 9'h000;
          // Wake only on a filtered rising edge
          if (pin_filt && !pin_prev)
            state <= SBT_IDLE;
        end
        default:
          state <= SBT_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      O_POWER_DOWN <= 1'b0;
    else if (I_CLOCK_EN)
      O_POWER_DOWN <= state == SBT_DOWN;
  end

  // On-time registers, values kept after expiry
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      for (int i = 0; i < 6; i++)
        on_time[i] <= STEP_RESET;
    else if (I_CLOCK_EN)
      for (int i = 0; i < 6; i++)
        if (wr_on[i])
          on_time[i] <= I_PWDATA[STEP_MSB:STEP_LSB];
  end

  // Compare on each tick; zero on-time never expires
  always_comb
  begin
    expired = 6'h00;
    any_armed = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      if (on_time[i] != STEP_RESET)
        any_armed = 1'b1;
      if (bal_run && tick && on_time[i] != STEP_RESET
          && next_bal_cnt >= step_ticks(on_time[i]))
        expired[i] = 1'b1;
    end
  end

  // Balance control; device powered down drops every output
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      bal <= BAL_RESET;
    else if (I_CLOCK_EN)
    begin
      if (state == SBT_DOWN)
        bal <= BAL_RESET;
      else if (wr_bal)
        bal <= I_PWDATA[BAL_MSB:BAL_LSB];
      // zero on-time on an active output drops it
      else
        for (int i = 0; i < 6; i++)
          if (expired[i] || (wr_on[i] && bal[i]
              && I_PWDATA[STEP_MSB:STEP_LSB] == STEP_RESET))
            bal[i] <= 1'b0;
    end
  end

  // Shared counter runs while any output is on, once started by a control write with an armed on-time
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      bal_cnt <= 9'h000;
      bal_run <= 1'b0;
    end
    else if (I_CLOCK_EN)
    begin
      if (state == SBT_DOWN || (wr_bal && I_PWDATA[BAL_MSB:BAL_LSB] == 6'h00))
      begin
        bal_run <= 1'b0;
        bal_cnt <= 9'h000;
      end
      // joining outputs use the running count
      else if (wr_bal && !bal_run && any_armed)
      begin
        bal_run <= 1'b1;
        bal_cnt <= 9'h000;
      end
      // restart on active rewrite; inactive has no effect
      else if ((wr_on & bal) != 6'h00)
        bal_cnt <= 9'h000;
      else if (bal_run && !wr_bal && (bal & ~expired) == 6'h00)
      begin
        bal_run <= 1'b0;
        bal_cnt <= 9'h000;
      end
      else if (bal_run && tick && bal_cnt != 9'h1ff)
        bal_cnt <= next_bal_cnt;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      O_BALANCE_DRIVE <= BAL_RESET;
    else if (I_CLOCK_EN)
      O_BALANCE_DRIVE <= bal;
  end

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST || !I_CLOCK_EN);

  sequence apb_wait_s;
    I_PSEL && I_PENABLE && !O_PREADY;
  endsequence

  apb_answer_a: assert property (apb_wait_s |=> O_PREADY)
    else $error("APB answer late");
  apb_unmapped_a: assert property (apb_wait_s and !rd_ok |=> O_PSLVERR)
    else $error("Unmapped address not flagged");
  expiry_pin_a: assert property (state == SBT_RUN && !wr_delay && tick
    && next_sleep_cnt >= step_ticks(sleep_delay)
    |=> state == ($past(pin_filt) ? SBT_IDLE : SBT_DOWN))
    else $error("Expiry did not follow the pin");
  run_holds_a: assert property (state == SBT_RUN && !tick && !wr_delay
    |=> state == SBT_RUN)
    else $error("Sleep timer left run without cause");
  zero_write_a: assert property (state == SBT_RUN && wr_delay && !pin_filt
    && I_PWDATA[STEP_MSB:STEP_LSB] == STEP_RESET
    |=> state == SBT_DOWN ##1 O_POWER_DOWN)
    else $error("Zero delay write did not power down");
  // outputs off
  // Output register trails bal by one cycle
  down_off_a: assert property (state == SBT_DOWN
    |=> bal == BAL_RESET ##1 O_BALANCE_DRIVE == BAL_RESET)
    else $error("Balance output on while down");
  bal_write_a: assert property (wr_bal && state != SBT_DOWN
    |=> bal == $past(I_PWDATA[BAL_MSB:BAL_LSB]))
    else $error("Balance write lost");
  active_rewrite_a: assert property ((wr_on & bal) != 6'h00 && !wr_bal
    && state != SBT_DOWN |=> bal_cnt == 9'h000)
    else $error("Active on-time write kept the count");
  idle_rewrite_a: assert property (wr_on != 6'h00 && (wr_on & bal) == 6'h00
    && bal_run && !wr_bal && !tick && (bal & ~expired) != 6'h00
    && state != SBT_DOWN |=> $stable(bal_cnt))
    else $error("Inactive on-time write moved the count");
  pin_filter_a: assert property ($changed(pin_filt)
    |-> $past(filt_cnt) == 31'(P_FILTER_CYCLES - 1))
    else $error("Sleep pin accepted too early");

endmodule

`default_nettype wire

// ---- tb/sbt_host_pins.sv ----
// Far-side model: host sleep pin driver and balance transistor gates.
// Assumes the bench commands the pin level each cycle.
`timescale 1ns/1ns
`default_nettype none

module sbt_host_pins
#(
  parameter int unsigned P_WAKE_CYCLES = 50
)
(
  // Clock
  input wire logic i_clock,
  // Commands and device pins
  input wire logic i_hold_low,
  input wire logic i_power_down,
  input wire logic [5:0] i_balance_drive,
  output logic o_sleep_request_n,
  output logic [5:0] o_gate_on,
  output logic o_host_ready
);
  // Starts at zero and counts up to P_WAKE_CYCLES; only read after a wake
  int unsigned settle;

  assign o_gate_on = i_balance_drive;

  always_ff @(posedge i_clock)
  begin
    o_sleep_request_n <= ~i_hold_low;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_power_down)
      settle <= 0;
    else if (settle < P_WAKE_CYCLES)
      settle <= settle + 1;
  end
  assign o_host_ready = (settle >= P_WAKE_CYCLES);
endmodule

`default_nettype wire

// ---- tb/sleep_and_balance_timers_tb_top.sv ----
// Testbench for the sleep and balance timer block over APB.
// Assumes shortened tick and filter counts for a short run.
`timescale 1ns/1ns
`default_nettype none

module sleep_and_balance_timers_tb_top;
  import sbt_pkg::*;
  localparam int T = 20;
  localparam int F = 4;
  localparam int STEP = 16 * T;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin_n;
  logic [5:0] drive;
  logic pd;
  logic host_low = 1'b0;
  logic host_ready;
  logic [31:0] q;
  logic e;
  int n;
  int err_count = 0;
  int samples_checked = 0;

  always #2 clk = ~clk;

  sbt_top #(.P_TICK_CYCLES(T), .P_FILTER_CYCLES(F)) dut_u (
    .I_CLOCK(clk), .I_SYS_RST(rst), .I_CLOCK_EN(clk_en),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_SLEEP_REQUEST_N(pin_n), .O_BALANCE_DRIVE(drive),
    .O_POWER_DOWN(pd));

  sbt_host_pins host_u (
    .i_clock(clk), .i_hold_low(host_low), .i_power_down(pd),
    .i_balance_drive(drive), .o_sleep_request_n(pin_n),
    .o_gate_on(), .o_host_ready(host_ready));

  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // One APB transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // Waits until {power down, drives} under mask equals v
  task automatic wait_out(input logic [6:0] m, input logic [6:0] v,
                          input int lim);
    for (n = 0; n < lim; n++)
    begin
      @(posedge clk);
      if ((({pd, drive} & m) ^ v) === 7'h00)
        break;
    end
    if (n >= lim)
    begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic in_step();
    chk(32'(n >= STEP - T && n <= STEP + F + 10), 32'h1);
  endtask

  task automatic wake();
    @(posedge clk);
    host_low <= 1'b0;
    wait_out(7'h40, 7'h00, F + 10);
    for (n = 0; n < 200 && host_ready !== 1'b1; n++)
      @(posedge clk);
    if (n >= 200)
    begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic pin_low();
    @(posedge clk);
    host_low <= 1'b1;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(SLEEP_DELAY_OFS, 32'h0);
    rd(BAL_CTRL_OFS, 32'h0);
    rd(ON_TIME0_OFS, 32'h0);
    rd(8'h28, 32'h0);
    chk(32'(e), 32'h1);
    // Untimed output, then a control write turns it off
    wr(BAL_CTRL_OFS, 32'h04);
    repeat (3) @(posedge clk);
    chk(32'(drive), 32'h01);
    wr(BAL_CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(drive), 32'h0);
    // Two timed outputs on one shared counter
    wr(ON_TIME0_OFS, 32'h08);
    wr(ON_TIME0_OFS + 8'h04, 32'h10);
    wr(BAL_CTRL_OFS, 32'h0c);
    wait_out(7'h3f, 7'h02, 2 * STEP);
    in_step();
    rd(BAL_CTRL_OFS, 32'h08);
    rd(ON_TIME0_OFS, 32'h08);
    // Third output joins the running count
    wr(ON_TIME0_OFS + 8'h08, 32'h08);
    wr(BAL_CTRL_OFS, 32'h18);
    wait_out(7'h3f, 7'h06, 5);
    wait_out(7'h3f, 7'h02, 2 * T + 5);
    wait_out(7'h3f, 7'h00, STEP + 10);
    // Rewrite of an active on-time restarts the count
    wr(ON_TIME0_OFS, 32'h10);
    wr(BAL_CTRL_OFS, 32'h04);
    repeat (400) @(posedge clk);
    wr(ON_TIME0_OFS, 32'h10);
    repeat (560) @(posedge clk);
    chk(32'(drive), 32'h01);
    wr(ON_TIME0_OFS, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(drive), 32'h0);
    // Short glitch is filtered out
    pin_low();
    repeat (2) @(posedge clk);
    host_low <= 1'b0;
    repeat (20) @(posedge clk);
    chk(32'(pd), 32'h0);
    // Frozen enable ignores a long low pulse
    clk_en <= 1'b0;
    pin_low();
    repeat (10) @(posedge clk);
    host_low <= 1'b0;
    repeat (3) @(posedge clk);
    clk_en <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(pd), 32'h0);
    // Zero delay: falling pin drops outputs and powers down
    wr(BAL_CTRL_OFS, 32'h04);
    pin_low();
    wait_out(7'h40, 7'h40, F + 10);
    repeat (2) @(posedge clk);
    chk(32'(drive), 32'h0);
    wake();
    // One step delay; pin back high before expiry keeps running
    wr(SLEEP_DELAY_OFS, 32'h08);
    rd(SLEEP_DELAY_OFS, 32'h08);
    pin_low();
    repeat (50) @(posedge clk);
    host_low <= 1'b0;
    rd(STATUS_OFS, 32'h0001_0000);
    chk(32'(q[17:16]), 32'h1);
    repeat (STEP + 20) @(posedge clk);
    chk(32'(pd), 32'h0);
    rd(STATUS_OFS, 32'h0);
    // One step delay with pin held low
    wr(BAL_CTRL_OFS, 32'h04);
    pin_low();
    wait_out(7'h40, 7'h40, 2 * STEP);
    in_step();
    repeat (2) @(posedge clk);
    chk(32'(drive), 32'h0);
    wake();
    // Soft sleep bit starts the timer
    wr(CONTROL_OFS, 32'h100);
    rd(STATUS_OFS, 32'h0001_0000);
    chk(32'(q[17:16]), 32'h1);
    pin_low();
    wait_out(7'h40, 7'h40, 2 * STEP);
    wake();
    // Zero written while running powers down at once
    wr(SLEEP_DELAY_OFS, 32'h10);
    pin_low();
    repeat (100) @(posedge clk);
    wr(SLEEP_DELAY_OFS, 32'h0);
    wait_out(7'h40, 7'h40, 10);
    wake();
    // Delay rewrite while running restarts the count
    wr(SLEEP_DELAY_OFS, 32'h08);
    pin_low();
    repeat (200) @(posedge clk);
    wr(SLEEP_DELAY_OFS, 32'h08);
    repeat (200) @(posedge clk);
    chk(32'(pd), 32'h0);
    wait_out(7'h40, 7'h40, STEP);
    wake();
    end_sim();
  end
endmodule

`default_nettype wire
